// File: verilog/gpc_pin_config.sv
// GPIO pin configuration, runtime registers and event detection over AHB-Lite
//
// Functional notes
// - Ports 0 and 1 have data out, data in, event enable, event status.
// - Every pin owns a seven-bit configuration register, reached indirectly.
// - Ports 2 and 3 have only data out and data in registers.
// - Ports 2 and 3 implement config bits 3-0; bits 6-4 reserved.
// - Base address low byte bits 3-0 read as zero.
// - Interrupt type resets to 03h; only bit 1 writable.
// - Both DMA report entries are read-only and return 04h.
// - Pin select chooses which per-pin register the config window reaches.
// - Port select bits 6-4 binary, ports 0 to 3; other codes reserved.
// - Pin select bits 2-0 give pin 0 to 7, default 0.
// - Pin select resets to 00h; bits 7 and 3 reserved.
// - Config window reads and writes act on the selected pin register.
// - Per-pin config resets to 44h for ports 0/1, 04h for 2/3.
// - Debounce enable passes pin to event logic after fixed stable period.
// - Polarity 0 falling/low, 1 rising/high.
// - Type 0 edge detection, 1 level detection.
// - Event bits of ports 2 and 3 always read zero.
// - Per-pin event routing register at F2h, reset 00h.
// - Activation register at 30h is read/write, resets to 00h.
// - Lock freezes direction, type, pull-up, output value; only reset clears.
// - Pull-up bit 2 enables internal pull-up, default on.
// - Output type 0 open-drain, 1 push-pull.
// - Output enable 0 floats pin, 1 drives it except open-drain high; input path unaffected.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "gpc_defines.svh"

module gpc_pin_config (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [31:0] pinIn,
  output logic [31:0]      pinOut,
  output logic [31:0]      pinOeN,
  output logic [31:0]      pinPullUp,
  output logic             irqRequest,
  output logic             smiRequest,
  output logic             wakeRequest
);

  localparam logic [7:0] DEB_LAST = 8'(`GPC_DEBOUNCE_CYC - 1);

  function automatic logic [4:0] pinIndex(input logic [2:0] port,
                                          input logic [2:0] pin);
    pinIndex = {port[1:0], pin};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic                 wrPending;
  logic                 rdPending;
  logic [7:0]           accIdx;
  logic                 accHit;
  gpc_pkg::gpc_byte_t   wd;
  gpc_pkg::gpc_byte_t   rdMux;
  logic                 addrTake;

  assign addrTake = hsel && htrans[1] && hready;
  assign wd       = hwdata[7:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPending <= 1'b0;
      rdPending <= 1'b0;
      accIdx    <= 8'h00;
      accHit    <= 1'b0;
    end else begin
      wrPending <= addrTake && hwrite;
      rdPending <= addrTake && !hwrite;
      if (addrTake) begin
        accIdx <= haddr[9:2];
        accHit <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0)
                  && (hsize == 3'h2);
      end
    end
  end

  // Reads take one wait state so a write just ahead is already applied
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end else begin
      hreadyout <= !(addrTake && !hwrite);
      hresp     <= 1'b0;
      if (rdPending) begin
        hrdata <= {24'h000000, accHit ? rdMux : 8'h00};
      end
    end
  end

  logic wrAny;
  assign wrAny = wrPending && accHit;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration entries

  gpc_pkg::gpc_byte_t unitActivate;
  gpc_pkg::gpc_byte_t baseHigh;
  gpc_pkg::gpc_byte_t baseLow;
  gpc_pkg::gpc_byte_t intNumber;
  gpc_pkg::gpc_byte_t intType;
  gpc_pkg::gpc_byte_t pinSelector;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unitActivate <= `GPC_RST_ACT;
      baseHigh     <= 8'h00;
      baseLow      <= 8'h00;
      intNumber    <= 8'h00;
      intType      <= `GPC_RST_ITYPE;
      pinSelector  <= `GPC_RST_PINSEL;
    end else if (wrAny) begin
      case (accIdx)
        `GPC_IDX_ACT:     unitActivate <= wd;
        `GPC_IDX_BASEHI:  baseHigh <= wd;
        `GPC_IDX_BASELO:  baseLow <= wd & `GPC_BASELO_MASK;
        `GPC_IDX_INTNUM:  intNumber <= wd;
        `GPC_IDX_INTTYPE: intType[`GPC_ITYPE_WBIT] <= wd[`GPC_ITYPE_WBIT];
        `GPC_IDX_PINSEL:  pinSelector <= wd & `GPC_PINSEL_MASK;
        default: ;
      endcase
    end
  end

  logic [2:0] selPort;
  logic [2:0] selPin;
  logic       selValid;
  logic       selEvt;
  logic [4:0] selIdx;

  assign selPort  = pinSelector[6:4];
  assign selPin   = pinSelector[2:0];
  assign selValid = selPort < `GPC_NUM_PORTS;
  assign selEvt   = selPort < `GPC_EVT_PORTS;
  assign selIdx   = pinIndex(selPort, selPin);

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin configuration and routing

  gpc_pkg::gpc_cfg_t   pinCfg [32];
  gpc_pkg::gpc_route_t pinRoute [16];
  logic [31:0]         lockVec;
  logic [31:0]         stdEvtBits;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        pinCfg[i] <= (i < 16) ? `GPC_RST_CFG_EVT : `GPC_RST_CFG_STD;
      end
    end else if (wrAny && accIdx == `GPC_IDX_PINCFG && selValid) begin
      for (int i = 0; i < 32; i++) begin
        if (selIdx == 5'(i)) begin
          // Lock bit is part of the frozen field, so it never clears
          if (!pinCfg[i][`GPC_CFG_LOCK]) begin
            pinCfg[i][3:0] <= wd[3:0];
          end
          if (i < 16) begin
            pinCfg[i][6:4] <= wd[6:4];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        pinRoute[i] <= `GPC_RST_ROUTE;
      end
    end else if (wrAny && accIdx == `GPC_IDX_ROUTE && selEvt) begin
      for (int i = 0; i < 16; i++) begin
        if (selIdx == 5'(i)) begin
          pinRoute[i] <= wd[2:0];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      lockVec[i]    = pinCfg[i][`GPC_CFG_LOCK];
      stdEvtBits[i] = (i >= 16) && (|pinCfg[i][6:4]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Runtime data and event registers

  logic [31:0] outData;
  logic [15:0] evtEnable;
  logic [15:0] evtStatus;
  logic [15:0] evtSet;
  logic        actOn;

  // Runtime registers answer only while the unit is active
  assign actOn = unitActivate[`GPC_ACT_BIT];

  function automatic logic [7:0] lockedWrite(input logic [7:0] old,
                                             input logic [7:0] nw,
                                             input logic [7:0] lk);
    lockedWrite = (old & lk) | (nw & ~lk);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outData <= 32'h00000000;
    end else if (wrAny && actOn) begin
      case (accIdx)
        `GPC_IDX_DOUT0: outData[7:0] <=
          lockedWrite(outData[7:0], wd, lockVec[7:0]);
        `GPC_IDX_DOUT1: outData[15:8] <=
          lockedWrite(outData[15:8], wd, lockVec[15:8]);
        `GPC_IDX_DOUT2: outData[23:16] <=
          lockedWrite(outData[23:16], wd, lockVec[23:16]);
        `GPC_IDX_DOUT3: outData[31:24] <=
          lockedWrite(outData[31:24], wd, lockVec[31:24]);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evtEnable <= 16'h0000;
    end else if (wrAny && actOn) begin
      case (accIdx)
        `GPC_IDX_EVEN0: evtEnable[7:0]  <= wd;
        `GPC_IDX_EVEN1: evtEnable[15:8] <= wd;
        default: ;
      endcase
    end
  end

  // Write-one-to-clear; a detection in the same cycle wins over the clear
  logic [15:0] evtClr;
  always_comb begin
    evtClr = 16'h0000;
    if (wrAny && actOn && accIdx == `GPC_IDX_EVST0) evtClr[7:0] = wd;
    if (wrAny && actOn && accIdx == `GPC_IDX_EVST1) evtClr[15:8] = wd;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evtStatus <= 16'h0000;
    end else begin
      evtStatus <= (evtStatus & ~evtClr) | evtSet;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin input path and event detection

  logic [31:0] pinMeta;
  logic [31:0] pinSync;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= 32'h00000000;
      pinSync <= 32'h00000000;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  logic [7:0]  debCnt [16];
  logic [15:0] debLevel;
  logic [15:0] evtSrc;
  logic [15:0] evtPrev;

  // Level must hold unchanged for the whole period before it is passed on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        debCnt[i] <= 8'h00;
      end
      debLevel <= 16'h0000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (pinSync[i] == debLevel[i]) begin
          debCnt[i] <= 8'h00;
        end else if (debCnt[i] == DEB_LAST) begin
          debCnt[i]   <= 8'h00;
          debLevel[i] <= pinSync[i];
        end else begin
          debCnt[i] <= debCnt[i] + 8'h01;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      evtSrc[i] = pinCfg[i][`GPC_CFG_DEB] ? debLevel[i] : pinSync[i];
      evtSet[i] = evtEnable[i] &&
                  (evtSrc[i] == pinCfg[i][`GPC_CFG_EPOL]) &&
                  (pinCfg[i][`GPC_CFG_ETYPE] ||
                   (evtPrev[i] != evtSrc[i]));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evtPrev <= 16'h0000;
    end else begin
      evtPrev <= evtSrc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and event requests

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut    <= 32'h00000000;
      pinOeN    <= 32'hffffffff;
      pinPullUp <= 32'h00000000;
    end else begin
      for (int i = 0; i < 32; i++) begin
        pinOut[i]    <= pinCfg[i][`GPC_CFG_OTYPE] && outData[i];
        pinOeN[i]    <= !(pinCfg[i][`GPC_CFG_OE] &&
                          (pinCfg[i][`GPC_CFG_OTYPE] || !outData[i]));
        pinPullUp[i] <= pinCfg[i][`GPC_CFG_PU];
      end
    end
  end

  logic [15:0] routeIrq;
  logic [15:0] routeSmi;
  logic [15:0] routeWake;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      routeIrq[i]  = pinRoute[i][0];
      routeSmi[i]  = pinRoute[i][1];
      routeWake[i] = pinRoute[i][2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqRequest  <= 1'b0;
      smiRequest  <= 1'b0;
      wakeRequest <= 1'b0;
    end else begin
      irqRequest  <= actOn && |(evtStatus & evtEnable & routeIrq);
      smiRequest  <= actOn && |(evtStatus & evtEnable & routeSmi);
      wakeRequest <= actOn && |(evtStatus & evtEnable & routeWake);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer

  always_comb begin
    rdMux = 8'h00;
    case (accIdx)
      `GPC_IDX_DOUT0:   rdMux = actOn ? outData[7:0] : 8'h00;
      `GPC_IDX_DIN0:    rdMux = actOn ? pinSync[7:0] : 8'h00;
      `GPC_IDX_EVEN0:   rdMux = actOn ? evtEnable[7:0] : 8'h00;
      `GPC_IDX_EVST0:   rdMux = actOn ? evtStatus[7:0] : 8'h00;
      `GPC_IDX_DOUT1:   rdMux = actOn ? outData[15:8] : 8'h00;
      `GPC_IDX_DIN1:    rdMux = actOn ? pinSync[15:8] : 8'h00;
      `GPC_IDX_EVEN1:   rdMux = actOn ? evtEnable[15:8] : 8'h00;
      `GPC_IDX_EVST1:   rdMux = actOn ? evtStatus[15:8] : 8'h00;
      `GPC_IDX_DOUT2:   rdMux = actOn ? outData[23:16] : 8'h00;
      `GPC_IDX_DIN2:    rdMux = actOn ? pinSync[23:16] : 8'h00;
      `GPC_IDX_DOUT3:   rdMux = actOn ? outData[31:24] : 8'h00;
      `GPC_IDX_DIN3:    rdMux = actOn ? pinSync[31:24] : 8'h00;
      `GPC_IDX_ACT:     rdMux = unitActivate;
      `GPC_IDX_BASEHI:  rdMux = baseHigh;
      `GPC_IDX_BASELO:  rdMux = baseLow & `GPC_BASELO_MASK;
      `GPC_IDX_INTNUM:  rdMux = intNumber;
      `GPC_IDX_INTTYPE: rdMux = intType;
      `GPC_IDX_DMA0:    rdMux = `GPC_DMA_NONE;
      `GPC_IDX_DMA1:    rdMux = `GPC_DMA_NONE;
      `GPC_IDX_PINSEL:  rdMux = pinSelector;
      `GPC_IDX_PINCFG:  rdMux = selValid ? {1'b0, pinCfg[selIdx]} : 8'h00;
      `GPC_IDX_ROUTE:   rdMux = selEvt ? {5'h00, pinRoute[selIdx[3:0]]} : 8'h00;
      default:          rdMux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic rdIsType;
  logic rdIsDma;
  logic rdIsCfgBad;
  assign rdIsType   = rdPending && accHit && accIdx == `GPC_IDX_INTTYPE;
  assign rdIsDma    = rdPending && accHit &&
                      (accIdx == `GPC_IDX_DMA0 || accIdx == `GPC_IDX_DMA1);
  assign rdIsCfgBad = rdPending && accHit && accIdx == `GPC_IDX_PINCFG
                      && !selValid;

  read_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    addrTake && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  int_type_a: assert property (@(posedge clk) disable iff (!rst_n)
    rdIsType |=> hrdata[0] && hrdata[7:2] == 6'h00)
    else $error("interrupt type fixed bits wrong");

  dma_report_a: assert property (@(posedge clk) disable iff (!rst_n)
    rdIsDma |=> hrdata == 32'h00000004)
    else $error("dma report not 04h");

  reserved_port_a: assert property (@(posedge clk) disable iff (!rst_n)
    rdIsCfgBad |=> hrdata == 32'h00000000)
    else $error("reserved port read not zero");

  lock_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    (lockVec & $past(lockVec)) == $past(lockVec))
    else $error("lock bit cleared");

  locked_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((outData ^ $past(outData)) & $past(lockVec)) == 32'h00000000)
    else $error("locked output value changed");

  std_event_a: assert property (@(posedge clk) disable iff (!rst_n)
    stdEvtBits == 32'h00000000)
    else $error("port 2/3 event bits set");

  sel_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pinSelector & 8'h88) == 8'h00)
    else $error("pin select reserved bits set");

  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    evtSet != 16'h0000 |=> (evtStatus & $past(evtSet)) == $past(evtSet))
    else $error("event lost under clear");

  base_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    rdPending && accHit && accIdx == `GPC_IDX_BASELO
    |=> hrdata[3:0] == 4'h0)
    else $error("base low nibble not zero");

endmodule // gpc_pin_config

// File: verilog/gpc_defines.svh
// Register indices, field positions, reset values and timing for the GPIO config block
`ifndef GPC_DEFINES_SVH
`define GPC_DEFINES_SVH

// Runtime register indices (byte address is four times the index)
`define GPC_IDX_DOUT0   8'h00
`define GPC_IDX_DIN0    8'h01
`define GPC_IDX_EVEN0   8'h02
`define GPC_IDX_EVST0   8'h03
`define GPC_IDX_DOUT1   8'h04
`define GPC_IDX_DIN1    8'h05
`define GPC_IDX_EVEN1   8'h06
`define GPC_IDX_EVST1   8'h07
`define GPC_IDX_DOUT2   8'h08
`define GPC_IDX_DIN2    8'h09
`define GPC_IDX_DOUT3   8'h0a
`define GPC_IDX_DIN3    8'h0b

// Configuration register indices
`define GPC_IDX_ACT     8'h30
`define GPC_IDX_BASEHI  8'h60
`define GPC_IDX_BASELO  8'h61
`define GPC_IDX_INTNUM  8'h70
`define GPC_IDX_INTTYPE 8'h71
`define GPC_IDX_DMA0    8'h74
`define GPC_IDX_DMA1    8'h75
`define GPC_IDX_PINSEL  8'hf0
`define GPC_IDX_PINCFG  8'hf1
`define GPC_IDX_ROUTE   8'hf2

// Per-pin configuration fields
`define GPC_CFG_OE      0
`define GPC_CFG_OTYPE   1
`define GPC_CFG_PU      2
`define GPC_CFG_LOCK    3
`define GPC_CFG_ETYPE   4
`define GPC_CFG_EPOL    5
`define GPC_CFG_DEB     6

// Other fields and masks
`define GPC_ACT_BIT     0
`define GPC_ITYPE_WBIT  1
`define GPC_BASELO_MASK 8'hf0
`define GPC_PINSEL_MASK 8'h77
`define GPC_EVT_PORTS   3'h2
`define GPC_NUM_PORTS   3'h4

// Reset and fixed values
`define GPC_RST_ACT     8'h00
`define GPC_RST_PINSEL  8'h00
`define GPC_RST_CFG_EVT 7'h44
`define GPC_RST_CFG_STD 7'h04
`define GPC_RST_ITYPE   8'h03
`define GPC_RST_ROUTE   3'h0
`define GPC_DMA_NONE    8'h04

// Timing: least debounce time rounds up to whole cycles
`define GPC_CLK_MHZ      100
`define GPC_DEBOUNCE_NS  2000
`define GPC_DEBOUNCE_CYC ((`GPC_DEBOUNCE_NS * `GPC_CLK_MHZ + 999) / 1000)

`endif

// File: verilog/gpc_pkg.sv
// Types shared by the GPIO configuration block
package gpc_pkg;
  typedef logic [6:0] gpc_cfg_t;
  typedef logic [2:0] gpc_route_t;
  typedef logic [7:0] gpc_byte_t;
endpackage

// File: verif/gpc_pin_partner.sv
// External pin model: each pin takes the DUT drive first, then the external driver, then pull-up or float
`timescale 1ns/1ps

module gpc_pin_partner (
  input  wire logic        clk,
  input  wire logic [31:0] pinOut,
  input  wire logic [31:0] pinOeN,
  input  wire logic [31:0] pinPullUp,
  input  wire logic [31:0] extEn,
  input  wire logic [31:0] extLevel,
  output logic      [31:0] pinIn
);
  logic [31:0] floatPat = 32'h0;

  // A floating pin without pull-up toggles, so it never looks stable
  always @(posedge clk) begin
    floatPat <= ~floatPat;
  end

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!pinOeN[i]) begin
        pinIn[i] = pinOut[i];
      end else if (extEn[i]) begin
        pinIn[i] = extLevel[i];
      end else begin
        pinIn[i] = pinPullUp[i] ? 1'b1 : floatPat[i];
      end
    end
  end
endmodule // gpc_pin_partner

// File: verif/gpio_pin_config_access_tb.sv
// Self-checking bench for the GPIO pin configuration block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  failures++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

module gpio_pin_config_access_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout, hresp, irqRequest, smiRequest, wakeRequest;
  logic [31:0] hrdata, pinIn, pinOut, pinOeN, pinPullUp;
  logic [31:0] extEn = 32'h0;
  logic [31:0] extLevel = 32'h0;
  logic [7:0]  vals [32];
  logic [7:0]  d;
  int          failures = 0;
  int          n_checks = 0;
  int          cycles = 0;

  always #5 clk = ~clk;

  gpc_pin_config i_dut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN),
    .pinPullUp(pinPullUp), .irqRequest(irqRequest),
    .smiRequest(smiRequest), .wakeRequest(wakeRequest)
  );

  gpc_pin_partner i_pins (
    .clk(clk), .pinOut(pinOut), .pinOeN(pinOeN), .pinPullUp(pinPullUp),
    .extEn(extEn), .extLevel(extLevel), .pinIn(pinIn)
  );

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A hang in the bus handshake ends here rather than running forever
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("Timeout reached");
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Called just after a rising edge; returns just after the data edge
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] t;
    bus(1'b1, idx, v, t);
  endtask

  task automatic rc(input string nm, input logic [7:0] idx,
                    input logic [7:0] ex, input logic [7:0] mk = 8'hff);
    logic [7:0] t;
    bus(1'b0, idx, 8'h0, t);
    `CHK(nm, ex & mk, t & mk)
  endtask

  task automatic sel(input logic [2:0] port, input logic [2:0] pin);
    wr(8'hf0, {1'b0, port, 1'b0, pin});
  endtask

  function automatic logic [7:0] cfgRst(int p);
    return (p < 2) ? 8'h44 : 8'h04;
  endfunction

  function automatic logic [7:0] cfgMask(int p, logic [7:0] v);
    return v & ((p < 2) ? 8'h7f : 8'h0f);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(10));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc("act", 8'h30, 8'h00);
    rc("baseHi", 8'h60, 8'h00);
    rc("baseLo", 8'h61, 8'h00);
    rc("intNum", 8'h70, 8'h00);
    rc("intType", 8'h71, 8'h03);
    rc("dma0", 8'h74, 8'h04);
    rc("dma1", 8'h75, 8'h04);
    rc("pinSel", 8'hf0, 8'h00);
    rc("route", 8'hf2, 8'h00);
    for (int p = 0; p < 4; p++) begin
      sel(3'(p), 3'($urandom()));
      rc("cfgRst", 8'hf1, cfgRst(p));
    end
    $display("Test reset values done");

    d = 8'($urandom());
    wr(8'h61, d);
    rc("baseLo", 8'h61, d & 8'hf0);
    wr(8'h71, ~d);
    rc("intType", 8'h71, {6'h0, ~d[1], 1'b1});
    wr(8'h74, d);
    rc("dma0", 8'h74, 8'h04);
    wr(8'h75, d);
    rc("dma1", 8'h75, 8'h04);
    wr(8'hf0, 8'hff);
    rc("pinSel", 8'hf0, 8'h77);
    foreach (vals[i]) begin
      vals[i] = 8'($urandom());
      wr((i % 3 == 0) ? 8'h30 : ((i % 3 == 1) ? 8'h60 : 8'h70), vals[i]);
    end
    rc("act", 8'h30, vals[30]);
    rc("baseHi", 8'h60, vals[31]);
    rc("intNum", 8'h70, vals[29]);
    $display("Test register access done");

    foreach (vals[i]) begin
      vals[i] = 8'($urandom()) & 8'hf7;
      sel(3'(i / 8), 3'(i % 8));
      wr(8'hf1, vals[i]);
    end
    foreach (vals[i]) begin
      sel(3'(i / 8), 3'(i % 8));
      rc("cfgPin", 8'hf1, cfgMask(i / 8, vals[i]));
    end
    sel(3'h2, 3'h0);
    wr(8'hf2, 8'h07);
    rc("route2", 8'hf2, 8'h00);
    sel(3'h4 + 3'($urandom() % 4), 3'h0);
    wr(8'hf1, 8'h55);
    rc("cfgRsvd", 8'hf1, 8'h00);
    sel(3'h0, 3'h0);
    rc("cfgKeep", 8'hf1, cfgMask(0, vals[0]));
    $display("Test pin select done");

    wr(8'h30, 8'h01);
    wr(8'h02, 8'h5a);
    rc("evEn0", 8'h02, 8'h5a);
    wr(8'h0c, 8'hff);
    rc("noEvEn2", 8'h0c, 8'h00);
    sel(3'h2, 3'h0);
    wr(8'hf1, 8'h03);
    wr(8'h08, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("pushOe", 1'b0, pinOeN[16])
    `CHK("pushOut", 1'b1, pinOut[16])
    `CHK("noPull", 1'b0, pinPullUp[16])
    rc("din2", 8'h09, 8'h01, 8'h01);
    wr(8'hf1, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("odHigh", 1'b1, pinOeN[16])
    wr(8'h08, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("odLow", 1'b0, pinOeN[16])
    wr(8'hf1, 8'h04);
    extEn[16] <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("float", 1'b1, pinOeN[16])
    `CHK("pull", 1'b1, pinPullUp[16])
    rc("dinFloat", 8'h09, 8'h00, 8'h01);
    $display("Test pin drive done");

    sel(3'h3, 3'h0);
    wr(8'hf1, 8'h07);
    wr(8'h0a, 8'h01);
    wr(8'hf1, 8'h0f);
    wr(8'hf1, 8'h00);
    wr(8'h0a, 8'h00);
    rc("lockCfg", 8'hf1, 8'h0f);
    rc("lockOut", 8'h0a, 8'h01, 8'h01);
    `CHK("lockPin", 2'b10, {pinOut[24], pinOeN[24]})
    $display("Test lock done");

    sel(3'h0, 3'h0);
    wr(8'hf1, 8'h04);
    wr(8'hf2, 8'h01);
    wr(8'h02, 8'h01);
    repeat (8) @(posedge clk);
    wr(8'h03, 8'hff);
    extEn[0] <= 1'b1;
    repeat (6) @(posedge clk);
    rc("stFall", 8'h03, 8'h01, 8'h01);
    `CHK("irq", 1'b1, irqRequest)
    wr(8'h03, 8'h01);
    repeat (4) @(posedge clk);
    rc("stEdge", 8'h03, 8'h00, 8'h01);
    wr(8'hf1, 8'h34);
    wr(8'h03, 8'h01);
    rc("stLow", 8'h03, 8'h00, 8'h01);
    extLevel[0] <= 1'b1;
    repeat (6) @(posedge clk);
    wr(8'h03, 8'h01);
    repeat (3) @(posedge clk);
    rc("stLevel", 8'h03, 8'h01, 8'h01);
    sel(3'h0, 3'h1);
    wr(8'hf1, 8'h44);
    wr(8'h02, 8'h02);
    repeat (250) @(posedge clk);
    wr(8'h03, 8'hff);
    extEn[1] <= 1'b1;
    repeat (100) @(posedge clk);
    extEn[1] <= 1'b0;
    repeat (300) @(posedge clk);
    rc("debShort", 8'h03, 8'h00, 8'h02);
    extEn[1] <= 1'b1;
    repeat (260) @(posedge clk);
    rc("debLong", 8'h03, 8'h02, 8'h02);
    $display("Test events done");
    wrap_up();
  end
endmodule // gpio_pin_config_access_tb
